// ### inc/rds_link_pkg.sv
// Constants for the demodulator-to-decoder bit link
package rds_link_pkg;
  // ==========================================================================
  // Clock and link timing
  localparam int unsigned SYS_CLK_KHZ      = 125000;
  localparam int unsigned BIT_RATE_MHZ_X10K = 11875;   // 1.1875 kHz in 1e-4 kHz units
  localparam int unsigned BIT_PERIOD_CYC   = (SYS_CLK_KHZ * 10000) / BIT_RATE_MHZ_X10K;
  localparam int unsigned CLK_HIGH_US      = 420;
  localparam int unsigned CLK_HIGH_CYC     = (CLK_HIGH_US * SYS_CLK_KHZ) / 1000;
  localparam int unsigned DECODER_CLK_KHZ  = 10400;
  // Data hold after the clock rise, at least one decoder clock, rounded up
  localparam int unsigned DATA_HOLD_CYC    = (SYS_CLK_KHZ + DECODER_CLK_KHZ - 1) / DECODER_CLK_KHZ;
  localparam int unsigned CNT_W            = 20;
  // ==========================================================================
  // Reset values and buffer depth
  localparam logic        CLK_RESET        = 1'b0;
  localparam logic        DATA_RESET       = 1'b0;
  localparam logic        SLIP_RESET       = 1'b0;
  localparam int unsigned BUF_DEPTH        = 2;
endpackage : rds_link_pkg

// ### hdl/rds_demod_decoder_link.sv
// Demodulator end of the demodulator-to-decoder RDS bit link
// Summary of operation
// - One bit clock pulse is sent to the decoder for every RDS bit period of 1.1875 kHz.
// - Each bit clock pulse stays high for about 420 us, half a bit period, then falls.
// - The data bit stays stable for at least one 10.4 MHz decoder clock after each clock rise.
// - The data output carries the bit being delivered, the one captured at the clock rise it changes together with.
// - Bit-slip and slip-process-active signalling exists in hardware even if firmware leaves it idle.
// - The link is four flag signals, with a connection-register path usable instead of flags five to seven.
// - With the first decoder attached, user flags five to eight carry clock, data, slip and active, unstretched.
`timescale 1ns/100ps
`default_nettype none
module rds_demod_decoder_link
  import rds_link_pkg::*;
#(
  parameter int unsigned BIT_PERIOD = BIT_PERIOD_CYC,
  parameter int unsigned HIGH_TIME  = CLK_HIGH_CYC
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic bit_in_valid,
  input  wire logic bit_in_data,
  input  wire logic bit_in_slip,
  output logic      bit_in_ready,
  input  wire logic use_conn_reg,
  output logic      conn_reg_valid,
  output logic      conn_reg_data,
  output logic      conn_reg_slip,
  output logic      user_flag_five,
  output logic      user_flag_six,
  output logic      user_flag_seven,
  input  wire logic user_flag_eight,
  output logic      slip_active
);

  // ==========================================================================
  // Two-entry buffer between bit source and link timer
  logic [1:0] buf_data_r, buf_data_nxt;
  logic [1:0] buf_slip_r, buf_slip_nxt;
  logic [1:0] buf_cnt_r,  buf_cnt_nxt;
  logic       pop;
  logic       ready_r;

  // Ready registered from the next fill level
  assign bit_in_ready = ready_r;

  always_comb begin
    buf_data_nxt = buf_data_r;
    buf_slip_nxt = buf_slip_r;
    buf_cnt_nxt  = buf_cnt_r;
    if (pop) begin
      buf_data_nxt = {1'b0, buf_data_r[1]};
      buf_slip_nxt = {1'b0, buf_slip_r[1]};
      buf_cnt_nxt  = buf_cnt_r - 2'h1;
    end
    if (bit_in_valid && bit_in_ready) begin
      buf_data_nxt[buf_cnt_nxt[0]] = bit_in_data;
      buf_slip_nxt[buf_cnt_nxt[0]] = bit_in_slip;
      buf_cnt_nxt                  = buf_cnt_nxt + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      buf_data_r <= 2'h0;
      buf_slip_r <= 2'h0;
      buf_cnt_r  <= 2'h0;
      ready_r    <= 1'b1;
    end else begin
      buf_data_r <= buf_data_nxt;
      buf_slip_r <= buf_slip_nxt;
      buf_cnt_r  <= buf_cnt_nxt;
      ready_r    <= (buf_cnt_nxt != 2'(BUF_DEPTH));
    end
  end

  // ==========================================================================
  // Bit period timer
  typedef enum logic [1:0] {IDLE, HIGH, LOW} link_state_t;
  link_state_t      state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] slip_cnt_r, slip_cnt_nxt;
  logic             clk_r, clk_nxt, data_r, data_nxt, slip_r, slip_nxt;
  logic             mux_r, mux_nxt;

  // Terminal count compare, shared by the slip and period timers
  function automatic logic at_count(input logic [CNT_W-1:0] value, input int unsigned target);
    return value == CNT_W'(target);
  endfunction : at_count

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    clk_nxt      = clk_r;
    data_nxt     = data_r;
    slip_nxt     = slip_r;
    slip_cnt_nxt = slip_cnt_r;
    mux_nxt      = use_conn_reg;
    pop          = 1'b0;
    if (slip_r) begin
      if (at_count(slip_cnt_r, BIT_PERIOD - 1)) begin
        slip_nxt = 1'b0;
      end else begin
        slip_cnt_nxt = slip_cnt_r + CNT_W'(1);
      end
    end
    case (state_r)
      IDLE: begin
        if (buf_cnt_r != 2'h0) begin
          // Data changes on the same edge as the clock rise
          pop       = 1'b1;
          data_nxt  = buf_data_r[0];
          if (buf_slip_r[0]) begin
            slip_nxt     = 1'b1;
            slip_cnt_nxt = '0;
          end
          cnt_nxt   = '0;
          clk_nxt   = 1'b1;
          state_nxt = HIGH;
        end
      end
      HIGH: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (at_count(cnt_r, HIGH_TIME - 1)) begin
          clk_nxt   = 1'b0;
          state_nxt = LOW;
        end
      end
      LOW: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        // Data held through the whole period, far beyond one decoder clock
        // Ends one cycle early: the idle pop cycle completes the period
        if (at_count(cnt_r, BIT_PERIOD - 2)) begin
          state_nxt = IDLE;
        end
      end
      default: state_nxt = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r    <= IDLE;
      cnt_r      <= '0;
      slip_cnt_r <= '0;
      clk_r      <= CLK_RESET;
      data_r     <= DATA_RESET;
      slip_r     <= SLIP_RESET;
      mux_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      slip_cnt_r <= slip_cnt_nxt;
      clk_r      <= clk_nxt;
      data_r     <= data_nxt;
      slip_r     <= slip_nxt;
      mux_r      <= mux_nxt;
    end
  end

  // ==========================================================================
  // Output flags, stretch off, registered
  logic f5_r;
  logic f6_r;
  logic f7_r;
  logic cr_v_r;
  logic cr_d_r;
  logic cr_s_r;
  logic act_r;
  logic f5_nxt;
  logic f6_nxt;
  logic f7_nxt;
  logic cr_v_nxt;
  logic cr_d_nxt;
  logic cr_s_nxt;
  logic act_nxt;

  // Flags follow the timer's next values, so they line up with its registers
  always_comb begin
    f5_nxt   = clk_nxt & ~mux_nxt;
    f6_nxt   = data_nxt & ~mux_nxt;
    f7_nxt   = slip_nxt & ~mux_nxt;
    cr_v_nxt = clk_nxt & mux_nxt;
    cr_d_nxt = data_nxt & mux_nxt;
    cr_s_nxt = slip_nxt & mux_nxt;
    act_nxt  = user_flag_eight;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      f5_r   <= 1'b0;
      f6_r   <= 1'b0;
      f7_r   <= 1'b0;
      cr_v_r <= 1'b0;
      cr_d_r <= 1'b0;
      cr_s_r <= 1'b0;
      act_r  <= 1'b0;
    end else begin
      f5_r   <= f5_nxt;
      f6_r   <= f6_nxt;
      f7_r   <= f7_nxt;
      cr_v_r <= cr_v_nxt;
      cr_d_r <= cr_d_nxt;
      cr_s_r <= cr_s_nxt;
      act_r  <= act_nxt;
    end
  end

  assign user_flag_five  = f5_r;
  assign user_flag_six   = f6_r;
  assign user_flag_seven = f7_r;
  assign conn_reg_valid  = cr_v_r;
  assign conn_reg_data   = cr_d_r;
  assign conn_reg_slip   = cr_s_r;
  assign slip_active     = act_r;

endmodule : rds_demod_decoder_link
`default_nettype wire

// ### tb/rds_link_monitor.sv
// Checker for the demodulator bit link ports
`timescale 1ns/100ps
`default_nettype none
module rds_link_monitor #(
  parameter int unsigned BIT_PERIOD = 40,
  parameter int unsigned HIGH_TIME  = 20
) (
  input wire logic sys_clk, reset, bit_in_valid, bit_in_ready, use_conn_reg,
  input wire logic conn_reg_valid, conn_reg_slip, slip_active,
  input wire logic user_flag_five, user_flag_six, user_flag_seven, user_flag_eight
);
  logic [7:0] hi_r, sl_r, gap_r;
  logic [1:0] occ_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Pulse, slip, gap and buffer occupancy counters
  always_ff @(posedge sys_clk or posedge reset)
    if (reset) {hi_r, sl_r, gap_r, occ_r} <= {8'h00, 8'h00, 8'hFF, 2'h0};
    else begin
      hi_r  <= user_flag_five ? hi_r + 8'h01 : 8'h00;
      sl_r  <= user_flag_seven ? ($rose(user_flag_five) ? 8'h01 : sl_r + 8'h01) : 8'h00;
      gap_r <= $rose(user_flag_five) ? 8'h01 : gap_r + 8'(gap_r != 8'hFF);
      occ_r <= occ_r + 2'(bit_in_valid && bit_in_ready) - 2'($rose(user_flag_five || conn_reg_valid));
    end
  sequence clk_rise;
    $rose(user_flag_five);
  endsequence
  // ==========================================================================
  // Properties
  a_high_time_len: assert property (!user_flag_five && hi_r != 8'h00 |-> hi_r == 8'(HIGH_TIME))
    else $error("bit clock high time wrong");
  a_bit_spacing: assert property (clk_rise ##0 gap_r != 8'hFF |-> gap_r >= 8'(BIT_PERIOD))
    else $error("bit clock pulses too close");
  a_data_held: assert property (user_flag_five && !$rose(user_flag_five) |-> $stable(user_flag_six))
    else $error("data moved while clock high");
  a_slip_len: assert property (!user_flag_seven && sl_r != 8'h00 |-> sl_r == 8'(BIT_PERIOD))
    else $error("slip high time wrong");
  a_slip_with_clk: assert property ($rose(user_flag_seven) |-> clk_rise)
    else $error("slip raised without a bit");
  a_active_echo: assert property ($rose(user_flag_eight) |=> $rose(slip_active))
    else $error("slip active not passed on");
  a_route_only: assert property (!(user_flag_five && conn_reg_valid) && ($past(use_conn_reg) || !conn_reg_slip))
    else $error("both link paths active");
  a_empty_ready: assert property (occ_r == 2'h0 |-> bit_in_ready)
    else $error("ready low with empty buffer");
endmodule : rds_link_monitor
bind rds_demod_decoder_link rds_link_monitor #(.BIT_PERIOD(BIT_PERIOD), .HIGH_TIME(HIGH_TIME)) mon_u (.*);
`default_nettype wire

// ### tb/rds_decoder_model.sv
// Behavioural decoder at the far end of the bit link
`timescale 1ns/100ps
`default_nettype none
module rds_decoder_model (
  input  wire logic sys_clk, reset, bit_clk, bit_data, bit_slip,
  output logic      slip_busy
);
  logic [1:0] got_q[$];
  logic       clk_r;
  always @(posedge sys_clk or posedge reset)
    if (reset) {clk_r, slip_busy} <= 2'h0;
    else begin
      clk_r     <= bit_clk;
      if (bit_clk && !clk_r) got_q.push_back({bit_slip, bit_data});
      slip_busy <= bit_slip;
    end
endmodule : rds_decoder_model
`default_nettype wire

// ### tb/rds_demod_decoder_link_tb.sv
// Self-checking bench for the demodulator bit link
`timescale 1ns/100ps
`default_nettype none
module rds_demod_decoder_link_tb;
  localparam int unsigned BP = 40, HT = 20;
  logic sys_clk = 1'b0, reset = 1'b1, bit_in_valid = 1'b0, bit_in_data = 1'b0, bit_in_slip = 1'b0;
  logic use_conn_reg = 1'b0, bit_in_ready, conn_reg_valid, conn_reg_data, conn_reg_slip, slip_active;
  logic user_flag_five, user_flag_six, user_flag_seven, user_flag_eight;
  logic [1:0] exp_q[$];
  int bad_count = 0, checks = 0, cyc = 0, seed = 32'h3118;
  always #4 sys_clk = ~sys_clk;
  rds_demod_decoder_link #(.BIT_PERIOD(BP), .HIGH_TIME(HT)) dut_u (.*);
  rds_decoder_model partner_u (.sys_clk, .reset, .bit_clk(user_flag_five | conn_reg_valid),
    .bit_data(user_flag_six | conn_reg_data), .bit_slip(user_flag_seven | conn_reg_slip), .slip_busy(user_flag_eight));
  task chk(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task push(input logic d, input logic s);
    bit_in_valid <= 1'b1;
    bit_in_data  <= d;
    bit_in_slip  <= s;
    @(negedge sys_clk);
    while (!bit_in_ready) @(negedge sys_clk);
    @(posedge sys_clk);
    exp_q.push_back({s, d});
  endtask : push
  // Back-to-back bits, then drain and compare captures in order
  task batch(input int n, input logic conn);
    logic d, s;
    use_conn_reg <= conn;
    for (int i = 0; i < n; i++) begin
      d = 1'($random(seed));
      s = (i == 1 || i == 2 || $random(seed) % 4 == 0);
      if (i == 3) begin
        @(negedge sys_clk);
        chk({7'h00, bit_in_ready}, 8'h00);
        @(posedge sys_clk);
      end
      push(d, s);
    end
    bit_in_valid <= 1'b0;
    repeat (n * (BP + HT + 1) + 20) @(posedge sys_clk);
    chk(8'(partner_u.got_q.size()), 8'(exp_q.size()));
    while (exp_q.size() > 0 && partner_u.got_q.size() > 0)
      chk({6'h00, partner_u.got_q.pop_front()}, {6'h00, exp_q.pop_front()});
    $display("batch done, conn %0d", conn);
  endtask : batch
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk({5'h00, user_flag_five, user_flag_six, user_flag_seven}, 8'h00);
    $display("reset test done");
    @(posedge sys_clk);
    batch(8, 1'b0);
    batch(4, 1'b1);
    close_out();
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      close_out();
    end
  end
endmodule : rds_demod_decoder_link_tb
`default_nettype wire
